// File: rtl/dsa_pkg.sv
package dsa_pkg;

  // ------------------------------------------------------------------
  // conversion geometry
  // ------------------------------------------------------------------
  localparam int RES_BITS = 13;
  localparam logic [3:0] LAST_CONV_BIT = 4'hC;
  localparam logic [3:0] FIRST_LSB_IDX = 4'h1;
  localparam logic [3:0] LAST_LSB_IDX = 4'hC;
  localparam logic [3:0] END_SAMPLE_FALL = 4'h1;
  localparam logic [12:0] SIGN_FLIP = 13'h1000;
  localparam logic [12:0] TRIAL_FIRST = 13'h1000;
  localparam logic [12:0] CODE_ZERO = 13'h0000;

  // ------------------------------------------------------------------
  // host clock floor, informative only
  // ------------------------------------------------------------------
  localparam int CONV_CLK_FLOOR_HZ = 85000;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [5:0] {
    DSA_IDLE = 6'h01,
    DSA_WAIT_RISE = 6'h02,
    DSA_SAMPLE = 6'h04,
    DSA_CONV = 6'h08,
    DSA_LSBF = 6'h10,
    DSA_ZEROS = 6'h20
  } dsa_state_e;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic cmp;
  } dsa_pins_s;

  typedef struct packed {
    logic rise;
    logic fall;
  } dsa_edges_s;

endpackage

// File: rtl/dsa_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module dsa_pin_sync
  import dsa_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // raw pins
  input wire dsa_pins_s pins_in,
  // synchronised levels and serial clock edges
  output dsa_pins_s pins_out,
  output dsa_edges_s sclk_edges_out
);

  dsa_pins_s meta_reg;
  dsa_pins_s sync_reg;
  logic sclk_prev_reg;

  // ------------------------------------------------------------------
  // two-flop synchroniser, first stage feeds only the second
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      meta_reg <= '{cs_n: 1'b1, sclk: 1'b0, cmp: 1'b0};
      sync_reg <= '{cs_n: 1'b1, sclk: 1'b0, cmp: 1'b0};
    end else begin
      meta_reg <= pins_in;
      sync_reg <= meta_reg;
    end
  end

  // ------------------------------------------------------------------
  // edge finder: any duty cycle, but each sclk level must last at least one system clock
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sync_reg.sclk;
    end
  end

  assign pins_out = sync_reg;
  assign sclk_edges_out.rise = sync_reg.sclk & ~sclk_prev_reg;
  assign sclk_edges_out.fall = ~sync_reg.sclk & sclk_prev_reg;

endmodule // dsa_pin_sync
`default_nettype wire

// File: rtl/dsa_readout.sv
`timescale 1ns/100ps
`default_nettype none
module dsa_readout
  import dsa_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // serial pins from host
  input wire logic chip_select_n_standby_in,
  input wire logic sclk_in,
  // analog front end
  input wire logic cmp_in,
  output logic track_out,
  output logic [12:0] dac_code_out,
  output logic standby_out,
  // serial data pin
  output logic dout_out,
  output logic dout_oe_out,
  // parallel result
  output logic [12:0] result_out,
  output logic result_valid_out
);

  dsa_pins_s pins_raw;
  dsa_pins_s pins_s;
  dsa_edges_s edg;
  dsa_state_e st_reg;
  logic armed_reg;
  logic [1:0] fill_reg;
  logic [3:0] cnt_reg;
  logic [12:0] sar_reg;
  logic [12:0] trial_reg;
  logic [12:0] kept;
  logic conv_bit;
  logic cs_low;

  function automatic logic [12:0] to_twos(input logic [12:0] ob);
    to_twos = ob ^ SIGN_FLIP;
  endfunction

  assign pins_raw = '{cs_n: chip_select_n_standby_in, sclk: sclk_in, cmp: cmp_in};

  dsa_pin_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .pins_in(pins_raw),
    .pins_out(pins_s),
    .sclk_edges_out(edg)
  );

  assign cs_low = ~pins_s.cs_n;
  // offset-binary trial keeps the bit when the difference is at or above it
  assign kept = pins_s.cmp ? (sar_reg | trial_reg) : sar_reg;
  // msb of offset binary is inverted sign, so flip it on the first bit
  assign conv_bit = pins_s.cmp ^ trial_reg[12];

  // ------------------------------------------------------------------
  // power-up arming: a select held low from reset is not a frame
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      fill_reg <= 2'h0;
      armed_reg <= 1'b0;
    end else begin
      // sync pipe still shows its reset high for two clocks; do not arm on it
      fill_reg <= {fill_reg[0], 1'b1};
      if (fill_reg[1] && !cs_low) begin
        armed_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // frame sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      st_reg <= DSA_IDLE;
      cnt_reg <= 4'h0;
    end else if (!cs_low) begin
      st_reg <= DSA_IDLE;
      cnt_reg <= 4'h0;
    end else begin
      case (st_reg)
        DSA_IDLE: begin
          if (armed_reg) begin
            st_reg <= DSA_WAIT_RISE;
          end
        end
        DSA_WAIT_RISE: begin
          if (edg.rise) begin
            st_reg <= DSA_SAMPLE;
            cnt_reg <= 4'h0;
          end
        end
        DSA_SAMPLE: begin
          if (edg.fall) begin
            if (cnt_reg == END_SAMPLE_FALL) begin
              st_reg <= DSA_CONV;
              cnt_reg <= 4'h0;
            end else begin
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        end
        DSA_CONV: begin
          if (edg.fall) begin
            if (cnt_reg == LAST_CONV_BIT) begin
              st_reg <= DSA_LSBF;
              cnt_reg <= FIRST_LSB_IDX;
            end else begin
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        end
        DSA_LSBF: begin
          if (edg.fall) begin
            if (cnt_reg == LAST_LSB_IDX) begin
              st_reg <= DSA_ZEROS;
            end else begin
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        end
        DSA_ZEROS: begin
          st_reg <= DSA_ZEROS;
        end
        default: begin
          st_reg <= DSA_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // sample switch and standby
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      track_out <= 1'b0;
      standby_out <= 1'b1;
    end else if (!cs_low) begin
      track_out <= 1'b0;
      standby_out <= 1'b1;
    end else begin
      standby_out <= 1'b0;
      if (st_reg == DSA_WAIT_RISE && edg.rise) begin
        track_out <= 1'b1;
      end else if (st_reg == DSA_SAMPLE && edg.fall && cnt_reg == END_SAMPLE_FALL) begin
        track_out <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // successive approximation, one decision per falling edge
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sar_reg <= CODE_ZERO;
      trial_reg <= TRIAL_FIRST;
      dac_code_out <= CODE_ZERO;
      result_out <= CODE_ZERO;
      result_valid_out <= 1'b0;
    end else begin
      result_valid_out <= 1'b0;
      if (st_reg == DSA_SAMPLE && edg.fall && cnt_reg == END_SAMPLE_FALL) begin
        sar_reg <= CODE_ZERO;
        trial_reg <= TRIAL_FIRST;
        dac_code_out <= to_twos(TRIAL_FIRST);
      end else if (st_reg == DSA_CONV && edg.fall && cs_low) begin
        sar_reg <= kept;
        trial_reg <= trial_reg >> 1;
        // 13-bit offset code cannot leave -4096..+4095
        dac_code_out <= to_twos(kept | (trial_reg >> 1));
        if (cnt_reg == LAST_CONV_BIT) begin
          result_out <= to_twos(kept);
          result_valid_out <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // serial output: data changes only on sclk falling edges; enable also drops on select high
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      dout_out <= 1'b0;
      dout_oe_out <= 1'b0;
    end else if (!cs_low) begin
      dout_oe_out <= 1'b0;
    end else if (edg.fall) begin
      case (st_reg)
        DSA_SAMPLE: begin
          if (cnt_reg == END_SAMPLE_FALL) begin
            dout_out <= 1'b0;
            dout_oe_out <= 1'b1;
          end
        end
        DSA_CONV: begin
          dout_out <= conv_bit;
        end
        DSA_LSBF: begin
          dout_out <= result_out[cnt_reg];
        end
        DSA_ZEROS: begin
          dout_out <= 1'b0;
        end
        default: begin
          dout_out <= dout_out;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  logic [4:0] conv_falls_reg;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || st_reg != DSA_CONV) begin
      conv_falls_reg <= 5'h00;
    end else if (edg.fall) begin
      conv_falls_reg <= conv_falls_reg + 5'h01;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  sequence seq_second_fall;
    st_reg == DSA_SAMPLE && edg.fall && cnt_reg == END_SAMPLE_FALL && cs_low;
  endsequence

  sequence seq_null_driven;
    !track_out && dout_oe_out && !dout_out;
  endsequence

  sequence seq_sign_fall;
    st_reg == DSA_CONV && edg.fall && cnt_reg == 4'h0 && cs_low;
  endsequence

  AST_TRACK_START: assert property (
    st_reg == DSA_WAIT_RISE && edg.rise && cs_low |=> track_out && st_reg == DSA_SAMPLE)
    else $error("sampling did not start on first rising edge");

  AST_HOLD_AND_NULL: assert property (seq_second_fall |=> seq_null_driven)
    else $error("hold or null bit wrong at second falling edge");

  AST_STANDBY: assert property (
    !cs_low |=> st_reg == DSA_IDLE && standby_out && !track_out)
    else $error("select high did not force standby");

  AST_RELEASED: assert property (
    !cs_low |=> !dout_oe_out)
    else $error("output driven while select high");

  AST_CHANGE_ON_FALL: assert property (
    $changed(dout_out) |-> $past(edg.fall))
    else $error("data changed away from a falling edge");

  AST_CONV_LENGTH: assert property (
    st_reg == DSA_CONV ##1 st_reg == DSA_LSBF |-> $past(conv_falls_reg) == 5'h0C)
    else $error("conversion did not take thirteen clocks");

  AST_SIGN_BIT: assert property (
    seq_sign_fall |=> dout_out == !$past(pins_s.cmp))
    else $error("sign bit does not follow comparison");

  AST_RESULT_FIRST_BIT: assert property (
    seq_sign_fall ##1 (st_reg == DSA_CONV)[*1] ##0 (result_valid_out == 1'b0)
    |-> dout_oe_out)
    else $error("sign bit sent while output released");

  AST_LSB_FIRST: assert property (
    st_reg == DSA_LSBF && edg.fall && cs_low |=> dout_out == result_out[$past(cnt_reg)])
    else $error("lsb first data wrong");

  AST_ZERO_TAIL: assert property (
    st_reg == DSA_ZEROS && edg.fall && cs_low |=> !dout_out)
    else $error("tail bits not zero");

endmodule // dsa_readout
`default_nettype wire

// File: tb/dsa_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module dsa_host_model (
  // clock
  input wire logic clk_sys_in,
  // serial pins
  output logic select_n_out,
  output logic sclk_out,
  input wire logic dout_in
);
  // select starts low, as after a power-up with the pin held low
  initial begin
    select_n_out = 1'b0;
    sclk_out = 1'b0;
  end

  // --------------------------------------------------
  // one frame of n clocks
  // --------------------------------------------------
  // clock idles low and never runs outside a frame; data is taken late
  // in the high phase, so short phases still see settled data
  task automatic frame(input int n, input int hi, input int lo, output logic [40:1] bits);
    bits = '0;
    select_n_out <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    for (int k = 1; k <= n; k++) begin
      sclk_out <= 1'b1;
      repeat (hi) @(posedge clk_sys_in);
      bits[k] = dout_in;
      sclk_out <= 1'b0;
      repeat (lo) @(posedge clk_sys_in);
    end
    select_n_out <= 1'b1;
    repeat (12) @(posedge clk_sys_in);
  endtask
endmodule // dsa_host_model
`default_nettype wire

// File: tb/differential_sar_adc_serial_readout_tb.sv
`timescale 1ns/100ps
`default_nettype none
module differential_sar_adc_serial_readout_tb;
  logic clk_sys_in = 1'b0;
  logic rst_n_in;
  logic cmp_in = 1'b0;
  logic select_n, sclk, track, standby, dout, dout_oe, valid;
  logic [12:0] dac_code, result;
  wire logic dout_pin;
  int vdiff = 0;
  int n_errors = 0;
  int checks = 0;
  int track_total = 0;
  int valid_total = 0;
  int vals[12] = '{0, 1, -1, 2, -2, 4095, 4094, -4095, -4096, 6000, -6000, 1365};

  always #4 clk_sys_in = ~clk_sys_in;
  // released pin reads as z, never as a stale level
  assign dout_pin = dout_oe ? dout : 1'bz;

  dsa_readout u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .chip_select_n_standby_in(select_n), .sclk_in(sclk), .cmp_in(cmp_in),
    .track_out(track), .dac_code_out(dac_code), .standby_out(standby),
    .dout_out(dout), .dout_oe_out(dout_oe), .result_out(result),
    .result_valid_out(valid));
  dsa_host_model u_host (.clk_sys_in(clk_sys_in), .select_n_out(select_n),
    .sclk_out(sclk), .dout_in(dout_pin));

  // ideal comparator plus activity counters
  always @(posedge clk_sys_in) begin
    cmp_in <= (vdiff >= int'($signed(dac_code)));
    if (track === 1'b1) track_total <= track_total + 1;
    if (valid === 1'b1) valid_total <= valid_total + 1;
  end

  // --------------------------------------------------
  // compares
  // --------------------------------------------------
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [12:0] exp, input logic [12:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_cnt(input string what, input int exp, input int got);
    checks++;
    if (got != exp) begin
      n_errors++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // bit seen during clock k of a frame
  function automatic logic exp_bit(input int k, input logic [12:0] r);
    if (k <= 2) return 1'bz;
    if (k == 3) return 1'b0;
    if (k <= 16) return r[16 - k];
    if (k <= 28) return r[k - 16];
    return 1'b0;
  endfunction

  // --------------------------------------------------
  // scenarios
  // --------------------------------------------------
  task automatic sc_refused();
    logic [40:1] bits;
    int c0;
    c0 = valid_total;
    u_host.frame(16, 10, 10, bits);
    for (int k = 1; k <= 16; k++) chk_bit("dout_unarmed", 1'bz, bits[k]);
    chk_cnt("valid_unarmed", 0, valid_total - c0);
  endtask

  task automatic sc_convert(input int v, input int hi, input int lo);
    logic [40:1] bits;
    logic [12:0] exp;
    int t0, c0;
    exp = 13'(v > 4095 ? 4095 : (v < -4096 ? -4096 : v));
    vdiff <= v;
    t0 = track_total;
    c0 = valid_total;
    u_host.frame(30, hi, lo, bits);
    for (int k = 1; k <= 30; k++) chk_bit("dout", exp_bit(k, exp), bits[k]);
    chk_word("result", exp, result);
    chk_word("dac_final", exp, dac_code);
    chk_cnt("track_cycles", 2 * hi + lo, track_total - t0);
    chk_cnt("valid_pulses", 1, valid_total - c0);
    chk_bit("oe_after", 1'b0, dout_oe);
    chk_bit("standby_after", 1'b1, standby);
  endtask

  task automatic sc_abort(input logic [12:0] held);
    logic [40:1] bits;
    int c0;
    vdiff <= 77;
    c0 = valid_total;
    u_host.frame(8, 10, 10, bits);
    for (int k = 1; k <= 8; k++) chk_bit("dout_abort", exp_bit(k, 13'h004D), bits[k]);
    chk_cnt("valid_abort", 0, valid_total - c0);
    chk_word("result_abort", held, result);
    chk_bit("oe_abort", 1'b0, dout_oe);
    chk_bit("standby_abort", 1'b1, standby);
  endtask

  task automatic summarize();
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // --------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------
  initial begin
    rst_n_in = 1'b0;
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    sc_refused();
    foreach (vals[i]) sc_convert(vals[i], 10, 10);
    sc_convert(-1234, 3, 5);
    sc_convert(1500, 40, 40);
    sc_abort(13'h05DC);
    sc_convert(0, 10, 10);
    summarize();
  end

  // roughly five times the expected run length
  initial begin
    repeat (60000) @(posedge clk_sys_in);
    n_errors++;
    summarize();
  end
endmodule // differential_sar_adc_serial_readout_tb
`default_nettype wire
